// ### logic/dmacc_top.sv
// Four-channel DMA control: per-channel registers on AXI4-Lite, a
// shared transfer sequencer, peripheral command bus and descriptor port.
// Assumes the system bus moves data and descriptors on request.
`timescale 1ns/1ps
module dmacc_top
	import dmacc_pkg::*;
(
	input wire logic aclk, // System clock, 250 MHz
	input wire logic aresetn, // Synchronous reset, active low
	input wire logic [31:0] s_axi_awaddr, // Write address
	input wire logic s_axi_awvalid, // Write address valid
	output logic s_axi_awready, // Write address ready
	input wire logic [31:0] s_axi_wdata, // Write data
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes
	input wire logic s_axi_wvalid, // Write data valid
	output logic s_axi_wready, // Write data ready
	output logic [1:0] s_axi_bresp, // Write response
	output logic s_axi_bvalid, // Write response valid
	input wire logic s_axi_bready, // Write response ready
	input wire logic [31:0] s_axi_araddr, // Read address
	input wire logic s_axi_arvalid, // Read address valid
	output logic s_axi_arready, // Read address ready
	output logic [31:0] s_axi_rdata, // Read data
	output logic [1:0] s_axi_rresp, // Read response
	output logic s_axi_rvalid, // Read data valid
	input wire logic s_axi_rready, // Read data ready
	input wire logic [NCH-1:0] xfer_req, // Peripheral transfer requests
	input wire logic [NCH-1:0] eof_req, // Peripheral end-of-frame stop
	output logic xfer_valid, // Transfer request to system bus
	input wire logic xfer_ready, // Transfer accepted
	output logic [1:0] xfer_chan, // Channel of the transfer
	output logic [23:0] xfer_src, // Source address
	output logic [23:0] xfer_dst, // Destination address
	output logic [1:0] xfer_width, // Transfer width code
	output logic [3:0] peripheral_cmd_bus, // Command field to peripheral
	output logic peripheral_cmd_strobe, // Command valid, first transfer
	output logic stat_req, // Status wanted from peripheral
	input wire logic stat_valid, // Status supplied
	input wire logic [3:0] stat_data, // Status value
	output logic desc_valid, // Descriptor access request
	input wire logic desc_ready, // Descriptor access done
	output logic desc_we, // Descriptor write-back
	output logic [23:0] desc_addr, // Descriptor address
	output logic [31:0] desc_wdata, // Control and length write-back
	input wire logic [127:0] desc_rdata, // Fetched descriptor
	output logic [NCH-1:0] irq_pulse // Per-channel interrupt event
);

	// ==========================================================
	// State
	// ==========================================================
	logic [15:0] ctl_reg [NCH];
	logic [15:0] cnt_reg [NCH];
	logic [23:0] src_reg [NCH];
	logic [23:0] dst_reg [NCH];
	logic [23:0] lp_reg [NCH];
	logic [23:0] next_lp_reg [NCH];
	logic [NCH-1:0] list_mode_reg;
	logic [NCH-1:0] fetch_pend_reg;
	logic [NCH-1:0] first_reg;
	dmacc_state_t state_reg;
	logic [1:0] cur_reg;
	logic term_reg;
	logic cmd_first_reg;
	logic [23:0] src_out_reg;
	logic [23:0] dst_out_reg;
	logic [1:0] wid_out_reg;
	logic [3:0] cmd_out_reg;
	logic [23:0] desc_addr_reg;
	logic [31:0] desc_wdata_reg;
	logic [NCH-1:0] irq_reg;
	logic aw_hold_reg;
	logic w_hold_reg;
	logic bvalid_reg;
	logic rvalid_reg;
	logic [31:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic [1:0] bresp_reg;
	logic [1:0] rresp_reg;
	logic [31:0] rdata_reg;

	// Address decode: {hit, channel, index within channel}
	function automatic logic [6:0] reg_decode(input logic [31:0] addr);
		logic [23:0] rel;
		rel = addr[25:2] - CTL_IDX;
		return {(addr[31:26] == ADDR_TOP_ZERO) && (rel < CH_SPAN),
			rel[5:4], rel[3:0]};
	endfunction : reg_decode

	// Holes in the channel window answer with an error
	function automatic logic sub_mapped(input logic [3:0] sub);
		case (sub)
			SUB_CTL, SUB_CTL_LO, SUB_CNT_HI, SUB_CNT_LO,
			SUB_DST_U, SUB_DST_H, SUB_DST_L,
			SUB_SRC_U, SUB_SRC_H, SUB_SRC_L,
			SUB_LP_U, SUB_LP_H, SUB_LP_L: return 1'b1;
			default: return 1'b0;
		endcase
	endfunction : sub_mapped

	// ==========================================================
	// AXI4-Lite slave
	// ==========================================================
	logic [6:0] wdec;
	logic [6:0] rdec;
	logic wr_fire;
	logic wr_hit;
	logic rd_ok;
	logic [31:0] rd_val;
	logic [1:0] wch;
	logic [1:0] rch;

	// Address and data are taken in either order, one write at a time
	assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
	assign s_axi_wready = !w_hold_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign wdec = reg_decode(aw_addr_reg);
	assign rdec = reg_decode(s_axi_araddr);
	assign wch = wdec[5:4];
	assign rch = rdec[5:4];
	assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
	assign wr_hit = wdec[6] && sub_mapped(wdec[3:0]);
	assign rd_ok = rdec[6] && sub_mapped(rdec[3:0]);

	// Write channel capture and response
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_hold_reg <= 1'b0;
			w_hold_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= '0;
			w_strb_reg <= '0;
			bresp_reg <= RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_hold_reg <= 1'b0;
				w_hold_reg <= 1'b0;
				bvalid_reg <= 1'b1;
				bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bready && bvalid_reg) begin
				bvalid_reg <= 1'b0;
			end
		end
	end

	// Read value: narrow registers sit in the low bits
	always_comb begin
		rd_val = '0;
		case (rdec[3:0])
			SUB_CTL: rd_val[15:0] = ctl_reg[rch];
			SUB_CTL_LO: rd_val[7:0] = ctl_reg[rch][7:0];
			SUB_CNT_HI: rd_val[7:0] = cnt_reg[rch][15:8];
			SUB_CNT_LO: rd_val[7:0] = cnt_reg[rch][7:0];
			SUB_DST_U: rd_val[7:0] = dst_reg[rch][23:16];
			SUB_DST_H: rd_val[7:0] = dst_reg[rch][15:8];
			SUB_DST_L: rd_val[7:0] = dst_reg[rch][7:0];
			SUB_SRC_U: rd_val[7:0] = src_reg[rch][23:16];
			SUB_SRC_H: rd_val[7:0] = src_reg[rch][15:8];
			SUB_SRC_L: rd_val[7:0] = src_reg[rch][7:0];
			SUB_LP_U: rd_val[7:0] = lp_reg[rch][23:16];
			SUB_LP_H: rd_val[7:0] = lp_reg[rch][15:8];
			SUB_LP_L: rd_val[7:0] = lp_reg[rch][7:0];
			default: rd_val = '0;
		endcase
		if (!rd_ok) begin
			rd_val = '0;
		end
	end

	// Read channel: data one edge after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid_reg <= 1'b0;
			rdata_reg <= '0;
			rresp_reg <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			rvalid_reg <= 1'b1;
			rdata_reg <= rd_val;
			rresp_reg <= rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_rready && rvalid_reg) begin
			rvalid_reg <= 1'b0;
		end
	end

	// ==========================================================
	// Channel pick and sequencer events
	// ==========================================================
	logic [1:0] pick;
	logic pick_any;
	logic pick_fetch;
	logic ev_load;
	logic ev_xfer;
	logic ev_stat;
	logic ev_finish;
	logic xfer_last;

	// Fixed priority, channel 0 highest; idle channels are never picked
	always_comb begin
		pick = '0;
		pick_any = 1'b0;
		pick_fetch = 1'b0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (fetch_pend_reg[i] || (ctl_reg[i][B_EN] && xfer_req[i] &&
					cnt_reg[i] != '0)) begin
				pick = 2'(i);
				pick_any = 1'b1;
				pick_fetch = fetch_pend_reg[i];
			end
		end
	end

	assign ev_load = (state_reg == ST_FETCH) && desc_ready;
	assign ev_xfer = (state_reg == ST_XFER) && xfer_ready;
	assign ev_stat = (state_reg == ST_STAT) && stat_valid;
	assign ev_finish = (state_reg == ST_FINISH);
	// Buffer ends at count zero or on a peripheral frame stop
	assign xfer_last = (cnt_reg[cur_reg] == CNT_ONE) ||
		eof_req[cur_reg];

	// Handshake outputs follow the state; data come from flip-flops
	assign xfer_valid = (state_reg == ST_XFER);
	assign xfer_chan = cur_reg;
	assign xfer_src = src_out_reg;
	assign xfer_dst = dst_out_reg;
	assign xfer_width = wid_out_reg;
	assign peripheral_cmd_bus = cmd_out_reg;
	assign peripheral_cmd_strobe = xfer_valid && cmd_first_reg;
	assign stat_req = (state_reg == ST_STAT);
	assign desc_valid = (state_reg == ST_FETCH) || (state_reg == ST_WBACK);
	assign desc_we = (state_reg == ST_WBACK);
	assign desc_addr = desc_addr_reg;
	assign desc_wdata = desc_wdata_reg;
	assign irq_pulse = irq_reg;

	// ==========================================================
	// Sequencer: one channel served at a time
	// ==========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_reg <= ST_IDLE;
			cur_reg <= '0;
			term_reg <= 1'b0;
			cmd_first_reg <= 1'b0;
			src_out_reg <= '0;
			dst_out_reg <= '0;
			wid_out_reg <= WID_BYTE;
			cmd_out_reg <= '0;
			desc_addr_reg <= '0;
			desc_wdata_reg <= '0;
			irq_reg <= '0;
		end else begin
			irq_reg <= '0;
			unique case (state_reg)
				ST_IDLE: begin
					if (pick_any) begin
						cur_reg <= pick;
						if (pick_fetch) begin
							desc_addr_reg <= lp_reg[pick];
							state_reg <= ST_FETCH;
						end else begin
							src_out_reg <= src_reg[pick];
							dst_out_reg <= dst_reg[pick];
							wid_out_reg <= ctl_reg[pick][B_WID +: 2];
							cmd_out_reg <= ctl_reg[pick][B_CMD +: 4];
							cmd_first_reg <= first_reg[pick];
							state_reg <= ST_XFER;
						end
					end
				end
				ST_FETCH: begin
					if (desc_ready) begin
						state_reg <= ST_IDLE;
					end
				end
				ST_XFER: begin
					if (xfer_ready) begin
						term_reg <= eof_req[cur_reg];
						cmd_first_reg <= 1'b0;
						if (xfer_last) begin
							// Frame-final buffers collect status first
							state_reg <= ctl_reg[cur_reg][B_EOF] ?
								ST_STAT : ST_CLOSE;
						end else begin
							state_reg <= ST_IDLE;
						end
					end
				end
				ST_STAT: begin
					if (stat_valid) begin
						state_reg <= ST_CLOSE;
					end
				end
				ST_CLOSE: begin
					if (list_mode_reg[cur_reg] &&
							!ctl_reg[cur_reg][B_LOOP]) begin
						desc_addr_reg <= lp_reg[cur_reg];
						desc_wdata_reg <= {ctl_reg[cur_reg],
							cnt_reg[cur_reg]};
						state_reg <= ST_WBACK;
					end else begin
						state_reg <= ST_FINISH;
					end
				end
				ST_WBACK: begin
					if (desc_ready) begin
						state_reg <= ST_FINISH;
					end
				end
				ST_FINISH: begin
					if (ctl_reg[cur_reg][B_BUFFER_END_IRQ_EN] || term_reg) begin
						irq_reg[cur_reg] <= 1'b1;
					end
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// ==========================================================
	// Channel register file: engine updates, then bus writes win
	// ==========================================================
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < NCH; i++) begin
				ctl_reg[i] <= '0;
				cnt_reg[i] <= '0;
				src_reg[i] <= '0;
				dst_reg[i] <= '0;
				lp_reg[i] <= '0;
				next_lp_reg[i] <= '0;
			end
			list_mode_reg <= '0;
			fetch_pend_reg <= '0;
			first_reg <= '0;
		end else begin
			if (ev_load) begin
				// Enable taken from a descriptor runs the list
				ctl_reg[cur_reg] <= desc_rdata[DESC_CTL_LSB +: 16];
				cnt_reg[cur_reg] <= desc_rdata[DESC_CNT_LSB +: 16];
				src_reg[cur_reg] <= desc_rdata[DESC_SRC_LSB +: 24];
				dst_reg[cur_reg] <= desc_rdata[DESC_DST_LSB +: 24];
				next_lp_reg[cur_reg] <= desc_rdata[DESC_NEXT_LSB +: 24];
				fetch_pend_reg[cur_reg] <= 1'b0;
				first_reg[cur_reg] <= 1'b1;
			end
			if (ev_xfer) begin
				cnt_reg[cur_reg] <= cnt_reg[cur_reg] - CNT_ONE;
				src_reg[cur_reg] <= step_addr(src_reg[cur_reg],
					ctl_reg[cur_reg][B_SRC +: 2],
					ctl_reg[cur_reg][B_WID +: 2]);
				dst_reg[cur_reg] <= step_addr(dst_reg[cur_reg],
					ctl_reg[cur_reg][B_DST +: 2],
					ctl_reg[cur_reg][B_WID +: 2]);
				first_reg[cur_reg] <= 1'b0;
			end
			if (ev_stat) begin
				ctl_reg[cur_reg][B_CMD +: 4] <= stat_data;
			end
			if (ev_finish) begin
				if (!list_mode_reg[cur_reg]) begin
					ctl_reg[cur_reg][B_EN] <= 1'b0;
				end else begin
					lp_reg[cur_reg] <= ctl_reg[cur_reg][B_JUMP] ?
						next_lp_reg[cur_reg] :
						lp_reg[cur_reg] + LIST_STEP;
					if (ctl_reg[cur_reg][B_HALT]) begin
						ctl_reg[cur_reg][B_EN] <= 1'b0;
					end else begin
						fetch_pend_reg[cur_reg] <= 1'b1;
					end
				end
			end
			if (wr_fire && wr_hit && w_strb_reg[0]) begin
				case (wdec[3:0])
					SUB_CTL, SUB_CTL_LO: ctl_reg[wch][7:0] <= w_data_reg[7:0];
					SUB_CNT_HI: cnt_reg[wch][15:8] <= w_data_reg[7:0];
					SUB_CNT_LO: cnt_reg[wch][7:0] <= w_data_reg[7:0];
					SUB_DST_U: dst_reg[wch][23:16] <= w_data_reg[7:0];
					SUB_DST_H: dst_reg[wch][15:8] <= w_data_reg[7:0];
					SUB_DST_L: dst_reg[wch][7:0] <= w_data_reg[7:0];
					SUB_SRC_U: src_reg[wch][23:16] <= w_data_reg[7:0];
					SUB_SRC_H: src_reg[wch][15:8] <= w_data_reg[7:0];
					SUB_SRC_L: src_reg[wch][7:0] <= w_data_reg[7:0];
					SUB_LP_U: lp_reg[wch][23:16] <= w_data_reg[7:0];
					SUB_LP_H: lp_reg[wch][15:8] <= w_data_reg[7:0];
					SUB_LP_L: begin
						lp_reg[wch][7:0] <= w_data_reg[7:0];
						list_mode_reg[wch] <= 1'b1;
						fetch_pend_reg[wch] <= 1'b1;
					end
					default: ;
				endcase
			end
			// Direct enable write: set wins over a same-cycle engine clear
			if (wr_fire && wr_hit && w_strb_reg[1] &&
					wdec[3:0] == SUB_CTL) begin
				ctl_reg[wch][15:8] <= w_data_reg[15:8];
				list_mode_reg[wch] <= 1'b0;
				fetch_pend_reg[wch] <= 1'b0;
				first_reg[wch] <= w_data_reg[B_EN];
			end
		end
	end
endmodule : dmacc_top

// ### logic/dmacc_pkg.sv
// Constants, field layout and helpers for the four-channel DMA control block.
// Assumes a 24-bit system address space and 32-bit AXI4-Lite data.
package dmacc_pkg;
	// ==========================================================
	// Channel count and register indices of channel 0
	// ==========================================================
	localparam int NCH = 4;
	localparam logic [23:0] CTL_IDX = 24'hFFE410;
	localparam logic [23:0] CTL_LO_IDX = 24'hFFE411;
	localparam logic [23:0] CNT_HI_IDX = 24'hFFE412;
	localparam logic [23:0] CNT_LO_IDX = 24'hFFE413;
	localparam logic [23:0] DST_U_IDX = 24'hFFE415;
	localparam logic [23:0] DST_H_IDX = 24'hFFE416;
	localparam logic [23:0] DST_L_IDX = 24'hFFE417;
	localparam logic [23:0] SRC_U_IDX = 24'hFFE419;
	localparam logic [23:0] SRC_H_IDX = 24'hFFE41A;
	localparam logic [23:0] SRC_L_IDX = 24'hFFE41B;
	localparam logic [23:0] LP_U_IDX = 24'hFFE41D;
	localparam logic [23:0] LP_H_IDX = 24'hFFE41E;
	localparam logic [23:0] LP_L_IDX = 24'hFFE41F;
	localparam logic [23:0] CH_SPAN = 24'h000040;
	localparam logic [5:0] ADDR_TOP_ZERO = 6'h00;
	// Index within one channel's 16-register window
	localparam logic [3:0] SUB_CTL = 4'(CTL_IDX - CTL_IDX);
	localparam logic [3:0] SUB_CTL_LO = 4'(CTL_LO_IDX - CTL_IDX);
	localparam logic [3:0] SUB_CNT_HI = 4'(CNT_HI_IDX - CTL_IDX);
	localparam logic [3:0] SUB_CNT_LO = 4'(CNT_LO_IDX - CTL_IDX);
	localparam logic [3:0] SUB_DST_U = 4'(DST_U_IDX - CTL_IDX);
	localparam logic [3:0] SUB_DST_H = 4'(DST_H_IDX - CTL_IDX);
	localparam logic [3:0] SUB_DST_L = 4'(DST_L_IDX - CTL_IDX);
	localparam logic [3:0] SUB_SRC_U = 4'(SRC_U_IDX - CTL_IDX);
	localparam logic [3:0] SUB_SRC_H = 4'(SRC_H_IDX - CTL_IDX);
	localparam logic [3:0] SUB_SRC_L = 4'(SRC_L_IDX - CTL_IDX);
	localparam logic [3:0] SUB_LP_U = 4'(LP_U_IDX - CTL_IDX);
	localparam logic [3:0] SUB_LP_H = 4'(LP_H_IDX - CTL_IDX);
	localparam logic [3:0] SUB_LP_L = 4'(LP_L_IDX - CTL_IDX);

	// ==========================================================
	// Control register fields and encodings
	// ==========================================================
	localparam int B_EN = 15;
	localparam int B_LOOP = 14;
	localparam int B_WID = 12;
	localparam int B_DST = 10;
	localparam int B_SRC = 8;
	localparam int B_BUFFER_END_IRQ_EN = 7;
	localparam int B_JUMP = 6;
	localparam int B_EOF = 5;
	localparam int B_HALT = 4;
	localparam int B_CMD = 0;
	localparam logic [1:0] WID_BYTE = 2'h0;
	localparam logic [1:0] WID_WORD = 2'h1;
	localparam logic [1:0] WID_QUAD = 2'h2;
	localparam logic [1:0] STEP_INC = 2'h1;
	localparam logic [1:0] STEP_DEC = 2'h2;
	localparam logic [23:0] LIST_STEP = 24'h000010;
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==========================================================
	// Descriptor layout (one 128-bit beat)
	// ==========================================================
	localparam int DESC_CTL_LSB = 112;
	localparam int DESC_CNT_LSB = 96;
	localparam int DESC_SRC_LSB = 72;
	localparam int DESC_DST_LSB = 48;
	localparam int DESC_NEXT_LSB = 24;

	typedef enum logic [2:0] {
		ST_IDLE, ST_FETCH, ST_XFER, ST_STAT, ST_CLOSE, ST_WBACK, ST_FINISH
	} dmacc_state_t;

	// Bytes moved per transfer; the reserved code behaves as a byte
	function automatic logic [23:0] width_bytes(input logic [1:0] wid);
		unique case (wid)
			WID_WORD: return 24'h000002;
			WID_QUAD: return 24'h000004;
			default: return 24'h000001;
		endcase
	endfunction : width_bytes

	// Next address after one transfer for a given stepping mode
	function automatic logic [23:0] step_addr(input logic [23:0] a,
			input logic [1:0] mode, input logic [1:0] wid);
		unique case (mode)
			STEP_INC: return a + width_bytes(wid);
			STEP_DEC: return a - width_bytes(wid);
			default: return a;
		endcase
	endfunction : step_addr
endpackage : dmacc_pkg

// ### sim/dmacc_top_assertions.sv
// Port-level checks of the DMA control block.
// Assumes one clock domain and the synchronous active-low reset.
`timescale 1ns/1ps
module dmacc_chk (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic s_axi_awvalid, // Aw valid
	input wire logic s_axi_awready, // Aw ready
	input wire logic s_axi_wvalid, // W valid
	input wire logic s_axi_wready, // W ready
	input wire logic s_axi_bvalid, // B valid
	input wire logic s_axi_arvalid, // Ar valid
	input wire logic s_axi_arready, // Ar ready
	input wire logic s_axi_rvalid, // R valid
	input wire logic xfer_valid, // Transfer request
	input wire logic xfer_ready, // Transfer done
	input wire logic [23:0] xfer_src, // Source
	input wire logic [23:0] xfer_dst, // Destination
	input wire logic peripheral_cmd_strobe, // Command strobe
	input wire logic [3:0] peripheral_cmd_bus, // Command field
	input wire logic stat_req, // Status wanted
	input wire logic stat_valid, // Status given
	input wire logic desc_valid, // Descriptor request
	input wire logic desc_ready, // Descriptor done
	input wire logic [3:0] irq_pulse // Interrupt events
);
	// ==========================================================
	// Handshake and sequencing checks
	// ==========================================================
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// Both write halves taken at one edge
	sequence aw_w_both;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	a_bresp_delay: assert property (aw_w_both |-> ##2 s_axi_bvalid)
		else $error("write response late");
	a_rdata_next: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid)
		else $error("read data late");
	// Payload must not move under a pending request
	a_xfer_held: assert property (xfer_valid && !xfer_ready |=>
		xfer_valid && $stable(xfer_src) && $stable(xfer_dst))
		else $error("transfer request dropped or changed");
	a_xfer_gap: assert property (xfer_valid && xfer_ready
		|=> !xfer_valid)
		else $error("no idle cycle after transfer");
	// Strobe and command stand with the request until it is taken
	a_cmd_held: assert property (peripheral_cmd_strobe && !xfer_ready
		|=> peripheral_cmd_strobe && xfer_valid &&
		$stable(peripheral_cmd_bus))
		else $error("command strobe dropped or changed");
	a_stat_held: assert property (stat_req && !stat_valid |=> stat_req)
		else $error("status request dropped");
	a_desc_held: assert property (desc_valid && !desc_ready
		|=> desc_valid)
		else $error("descriptor request dropped");
	a_irq_single: assert property (|irq_pulse |=> irq_pulse == 4'h0)
		else $error("interrupt pulse too long");
endmodule : dmacc_chk
bind dmacc_top dmacc_chk u_chk (.*);

// ### sim/dmacc_far_model.sv
// Far side: system bus and peripheral answering the sequencer.
// Assumes at most one of the three requests is open at a time.
`timescale 1ns/1ps
module dmacc_far_model #(
	parameter logic [127:0] DESC = 128'h8033000100400000500000F000000000,
	parameter logic [127:0] DESC2 = 128'hC0D1000100400000500000F000000000,
	parameter logic [3:0] STAT = 4'hC
) (
	input wire logic aclk, // Clock
	input wire logic aresetn, // Reset, active low
	input wire logic slow, // Answer late
	input wire logic xfer_valid, // Transfer request
	output logic xfer_ready, // Transfer done
	input wire logic desc_valid, // Descriptor request
	output logic desc_ready, // Descriptor done
	output logic [127:0] desc_rdata, // Descriptor
	input wire logic stat_req, // Status wanted
	output logic stat_valid, // Status given
	output logic [3:0] stat_data // Status value
);
	// ==========================================================
	// Shared wait counter: one cycle prompt, three when slow
	// ==========================================================
	logic [1:0] wait_reg;
	logic go;
	assign go = wait_reg == (slow ? 2'h3 : 2'h1);
	always_ff @(posedge aclk) begin
		if (!aresetn || go)
			wait_reg <= 2'h0;
		else if (xfer_valid || desc_valid || stat_req)
			wait_reg <= wait_reg + 2'h1;
	end
	// Lines outside a handshake show the inverse, never a stale value
	assign xfer_ready = xfer_valid && go;
	assign desc_ready = desc_valid && go;
	assign desc_rdata = desc_ready ? (slow ? DESC2 : DESC) : ~DESC;
	assign stat_valid = stat_req && go;
	assign stat_data = stat_valid ? STAT : ~STAT;
endmodule : dmacc_far_model

// ### sim/tb.sv
// Testbench: AXI4-Lite register tasks, direct and list transfers.
// Assumes the far-side model answers transfers, descriptors, status.
`timescale 1ns/1ps
module tb;
	import dmacc_pkg::*;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready, slow, wbd = 1'b0;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [31:0] desc_wdata, wb;
	logic [3:0] s_axi_wstrb, peripheral_cmd_bus, stat_data, xfer_req;
	logic [3:0] eof_req, irq_pulse;
	logic [1:0] s_axi_bresp, s_axi_rresp, xfer_chan, xfer_width;
	logic xfer_valid, xfer_ready, peripheral_cmd_strobe, stat_req;
	logic stat_valid, desc_valid, desc_ready, desc_we;
	logic [23:0] xfer_src, xfer_dst, desc_addr, fa, wa;
	logic [127:0] desc_rdata;
	logic [56:0] q[$];
	int num_errors, comparisons, nirq = 0, k, n0;
	dmacc_top u_dut (.*);
	dmacc_far_model u_far (.*);
	// ==========================================================
	// Clock, monitor and report
	// ==========================================================
	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end
	// Record transfers, interrupts and descriptor traffic
	always @(posedge aclk) begin
		if (xfer_valid && xfer_ready)
			q.push_back({peripheral_cmd_strobe, peripheral_cmd_bus,
				xfer_width, xfer_chan, xfer_src, xfer_dst});
		if (|irq_pulse)
			nirq++;
		if (desc_valid && desc_ready && desc_we) begin
			wbd = 1'b1;
			wa = desc_addr;
			wb = desc_wdata;
		end
		if (desc_valid && desc_ready && !desc_we)
			fa = desc_addr;
	end
	task automatic check(input string n, input logic [63:0] s, e);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", n, e, s);
		end
	endtask : check
	task automatic results;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : results
	function automatic logic [23:0] ra(input int c, input logic [3:0] s);
		return CTL_IDX + 24'(c * 16) + {20'h0, s};
	endfunction : ra
	// ==========================================================
	// Register bus tasks
	// ==========================================================
	task automatic wr(input logic [23:0] i, input logic [31:0] d,
			input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		s_axi_awaddr <= {ADDR_TOP_ZERO, i, 2'b00};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		check("bresp", s_axi_bresp, er);
	endtask : wr
	task automatic rd(input logic [23:0] i, input logic [31:0] e,
			input logic [1:0] er = RESP_OKAY);
		@(posedge aclk);
		s_axi_araddr <= {ADDR_TOP_ZERO, i, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		check("rdata", s_axi_rdata, e);
		check("rresp", s_axi_rresp, er);
	endtask : rd
	// One direct-mode buffer; an end-of-frame stop cuts it to one datum
	task automatic run(input int c, input logic [1:0] w, dm, sm,
			input logic ie, ef, sl, input logic [15:0] n);
		logic [23:0] s, d, b;
		logic [15:0] ctl, m;
		int i0;
		b = w == WID_QUAD ? 24'h4 : (w == WID_WORD ? 24'h2 : 24'h1);
		s = 24'h00A000;
		d = 24'h123456;
		ctl = {1'b1, 1'b0, w, dm, sm, ie, 3'h0, 4'h9};
		m = ef ? CNT_ONE : n;
		slow <= sl;
		wr(ra(c, SUB_DST_U), 32'h12);
		wr(ra(c, SUB_DST_H), 32'h34);
		wr(ra(c, SUB_DST_L), 32'h56);
		wr(ra(c, SUB_SRC_H), 32'hA0);
		wr(ra(c, SUB_SRC_L), 32'h00);
		wr(ra(c, SUB_CNT_HI), {24'h0, n[15:8]});
		wr(ra(c, SUB_CNT_LO), {24'h0, n[7:0]});
		q.delete();
		i0 = nirq;
		eof_req[c] <= ef;
		xfer_req[c] <= 1'b1;
		wr(ra(c, SUB_CTL), {16'h0, ctl});
		for (int t = 0; t < 200 && q.size() < m; t++)
			@(posedge aclk);
		xfer_req[c] <= 1'b0;
		eof_req[c] <= 1'b0;
		// Window for the close and its interrupt, and for stray transfers
		repeat (20) @(posedge aclk);
		check("count", q.size(), m);
		for (int t = 0; t < m; t++) begin
			check("xfer", q[t], {t == 0, 4'h9, w, 2'(c), s, d});
			s = sm == STEP_INC ? s + b : (sm == STEP_DEC ? s - b : s);
			d = dm == STEP_INC ? d + b : (dm == STEP_DEC ? d - b : d);
		end
		check("irq", nirq - i0, ie | ef);
		rd(ra(c, SUB_CNT_LO), {24'h0, 8'(n - m)});
		rd(ra(c, SUB_CTL), {17'h0, ctl[14:0]});
		$display("direct run on channel %0d done", c);
	endtask : run
	// ==========================================================
	// Tests
	// ==========================================================
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, slow} = 3'h0;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = 96'h0;
		{xfer_req, eof_req, num_errors, comparisons} = 0;
		s_axi_wstrb = 4'hF;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (k = 0; k < 4; k++) begin
			rd(ra(k, SUB_CTL), 32'h0);
			rd(ra(k, SUB_CNT_HI), 32'h0);
			rd(ra(k, SUB_DST_U), 32'h0);
			wr(ra(k, SUB_DST_L), 32'h40 + 32'(k));
		end
		for (k = 0; k < 4; k++)
			rd(ra(k, SUB_DST_L), 32'h40 + 32'(k));
		rd(ra(0, 4'h4), 32'h0, RESP_SLVERR);
		wr(ra(0, 4'h4), 32'hFF, RESP_SLVERR);
		$display("register test done");
		run(0, WID_WORD, STEP_INC, STEP_DEC, 1, 0, 0, 16'h0003);
		run(1, WID_BYTE, STEP_DEC, 2'h0, 0, 0, 1, 16'h0002);
		run(2, WID_QUAD, 2'h0, STEP_INC, 1, 0, 0, 16'h0002);
		run(3, WID_BYTE, STEP_INC, STEP_INC, 0, 1, 0, 16'h0105);
		// List mode: one end-of-frame buffer, halt, write-back
		xfer_req[0] <= 1'b1;
		wr(ra(0, SUB_LP_U), 32'h00);
		wr(ra(0, SUB_LP_H), 32'h20);
		q.delete();
		n0 = nirq;
		wr(ra(0, SUB_LP_L), 32'h00);
		for (k = 0; k < 200 && !wbd; k++)
			@(posedge aclk);
		repeat (20) @(posedge aclk);
		check("fetch", fa, 24'h002000);
		check("xfer", q[0], {5'h13, 4'h0, 48'h004000005000});
		check("wb", {wa, wb}, {24'h002000, 32'h803C0000});
		check("irq", nirq - n0, 0);
		rd(ra(0, SUB_LP_L), 32'h10);
		rd(ra(0, SUB_CTL), 32'h3C);
		// Second list buffer: loop, jump, buffer interrupt, no write-back
		slow <= 1'b1;
		n0 = nirq;
		wr(ra(0, SUB_LP_L), 32'h00);
		repeat (40) @(posedge aclk);
		check("irq", nirq - n0, 1);
		check("wb", wb, 32'h803C0000);
		rd(ra(0, SUB_LP_H), 32'hF0);
		rd(ra(0, SUB_CTL), 32'h40D1);
		$display("list test done");
		results();
	end
	// Watchdog well beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge aclk);
		num_errors++;
		results();
	end
endmodule : tb
